// *** rtl/ssat_defs.svh ***
// Constants of the single-slope converter timer
`ifndef SSAT_DEFS_SVH
`define SSAT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SSAT_OFF_MODE 8'h00
`define SSAT_OFF_SYNC_WIDTH 8'h04
`define SSAT_OFF_TRIM 8'h08
`define SSAT_OFF_RESULT_ONE 8'h0c
`define SSAT_OFF_RESULT_TWO 8'h10
`define SSAT_OFF_RESULT_THREE 8'h14
`define SSAT_OFF_RESULT_AUX 8'h18
`define SSAT_OFF_SYNC_PERIOD 8'h1c
`define SSAT_OFF_STATUS 8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SSAT_MODE_SEL_LO 0
`define SSAT_MODE_SEL_HI 1
`define SSAT_MODE_RATE 7
`define SSAT_MODE_DOUBLE 9
`define SSAT_MODE_RUN 10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSAT_RST_MODE 11'h000
`define SSAT_RST_TRIM 3'h0
`define SSAT_RST_SYNC_WIDTH 8'h28
`define SSAT_RST_SYNC_PERIOD 16'h2000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSAT_CLK_NS 50
`define SSAT_SYNC_MIN_NS 50
`define SSAT_SYNC_MAX_NS 12500
`define SSAT_SYNC_MIN_CYC ((`SSAT_SYNC_MIN_NS + `SSAT_CLK_NS - 1) / `SSAT_CLK_NS)
`define SSAT_SYNC_MAX_CYC (`SSAT_SYNC_MAX_NS / `SSAT_CLK_NS)
`define SSAT_FULL_SCALE 12'hfff
`define SSAT_TRIP_FLUSH 3'h4

`endif

// *** rtl/ssat_pkg.sv ***
// Types of the single-slope converter timer
package ssat_pkg;

  typedef struct packed {
    logic [10:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ssat_bus_req_t;

  typedef enum logic [2:0] {
    SSAT_ST_IDLE = 3'b001,
    SSAT_ST_SYNC = 3'b010,
    SSAT_ST_RAMP = 3'b100
  } ssat_state_t;

  typedef struct packed {
    logic rate;
    logic [1:0] sel;
  } ssat_mode_t;

endpackage : ssat_pkg

// *** rtl/ssat_capture.sv ***
// One channel result register of the converter
`timescale 1ns/1ps
`default_nettype none
`include "ssat_defs.svh"

module ssat_capture #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Conversion control
  input wire logic start_i,
  input wire logic ramp_i,
  input wire logic trip_i,
  input wire logic [WIDTH-1:0] count_i,
  // Result
  output logic [WIDTH-1:0] result_o
);

  logic done;
  logic [WIDTH-1:0] held;

  // --------------------------------------------------------------------------
  // Capture once per interval
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done <= 1'b0;
      held <= '0;
    end
    else if (start_i)
    begin
      done <= 1'b0;
      held <= '0;
    end
    else if (ramp_i && trip_i && !done)
    begin
      done <= 1'b1; // see [RULE_19]
      held <= count_i; // see [RULE_06]
    end
  end

  // Publish at end of interval; no trip gives zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      result_o <= '0;
    else if (start_i)
      result_o <= done ? held : '0; // see [RULE_13]
  end

endmodule : ssat_capture
`default_nettype wire

// *** rtl/ssat_timer.sv ***
// Single-slope converter timer: sync, ramp counter, captures, registers
// ----------------------------------------------------------------------------
// Notes on behaviour
// [RULE_01] Four comparators share one counter
// [RULE_02] Fourth channel goes through 4-to-1 selector
// [RULE_03] Mode bits 1:0 pick aux input
// [RULE_04] Code 11 converts internal reference
// [RULE_05] 12-bit counter measures time to crossing
// [RULE_06] Result captures counter when comparator trips
// [RULE_07] Each sync pulse restarts ramp and counter
// [RULE_08] Sync width from register, 0.05-12.5 us
// [RULE_09] Software makes sync wide enough
// [RULE_10] Mode bit 7 picks counter rate
// [RULE_11] Count limited to 4095
// [RULE_12] Double update halves conversion interval
// [RULE_13] No crossing reports zero
// [RULE_14] 3-bit trim steers ramp current
// [RULE_15] Current rises with trim code
// [RULE_16] Trim resets to zero
// [RULE_17] Software raises trim while result exceeds target
// [RULE_18] Counter zero during sync, stops full
// [RULE_19] One capture per interval, held
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "ssat_defs.svh"

module ssat_timer #(
  parameter int CNT_W = 12,
  parameter int PERIOD_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [10:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Comparators: main one..three, then selected aux
  input wire logic [3:0] comp_trip_i,
  // Analog control
  output logic [1:0] aux_select_o,
  output logic [2:0] ramp_current_trim_o,
  output logic ramp_discharge_o,
  output logic pwm_sync_pulse_o
);

  ssat_pkg::ssat_bus_req_t req;
  ssat_pkg::ssat_mode_t mode;
  ssat_pkg::ssat_state_t state;
  ssat_pkg::ssat_state_t next_state;
  logic rst_s1;
  logic rst_n;
  logic [3:0] trip_s1;
  logic [3:0] trip_s2;
  logic [3:0] trip_s3;
  logic [3:0] trip;
  logic double_update;
  logic run;
  logic [7:0] sync_width;
  logic [PERIOD_W-1:0] sync_period;
  logic [2:0] trim;
  logic [PERIOD_W-1:0] period_cnt;
  logic [7:0] width_cnt;
  logic [CNT_W-1:0] count;
  logic half_tick;
  logic tick;
  logic start;
  logic [PERIOD_W-1:0] interval;
  logic [CNT_W-1:0] result [4];
  logic [31:0] next_rdata;
  logic [2:0] settle;
  logic capture_ok;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // --------------------------------------------------------------------------
  // Comparator synchronisers, change on agreement of stages two and three
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip_s1 <= '0;
      trip_s2 <= '0;
      trip_s3 <= '0;
      trip <= '0;
    end
    else
    begin
      trip_s1 <= comp_trip_i;
      trip_s2 <= trip_s1;
      trip_s3 <= trip_s2;
      trip <= (trip_s2 & trip_s3) | (trip & (trip_s2 | trip_s3));
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [10:0] a, input logic [7:0] off);
    hit = (a == {3'h0, off});
  endfunction : hit

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= '0;
      double_update <= 1'b0;
      run <= 1'b0;
    end
    else if (req.wr && hit(req.addr, `SSAT_OFF_MODE))
    begin
      mode.sel <= req.wdata[`SSAT_MODE_SEL_HI:`SSAT_MODE_SEL_LO]; // see [RULE_03]
      mode.rate <= req.wdata[`SSAT_MODE_RATE]; // see [RULE_10]
      double_update <= req.wdata[`SSAT_MODE_DOUBLE];
      run <= req.wdata[`SSAT_MODE_RUN];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      trim <= `SSAT_RST_TRIM; // see [RULE_16]
    else if (req.wr && hit(req.addr, `SSAT_OFF_TRIM))
      trim <= req.wdata[2:0]; // see [RULE_14]
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_width <= `SSAT_RST_SYNC_WIDTH;
      sync_period <= `SSAT_RST_SYNC_PERIOD;
    end
    else if (req.wr)
    begin
      if (hit(req.addr, `SSAT_OFF_SYNC_WIDTH))
      begin
        // Clamp to 1..250 cycles, 0.05 to 12.5 us
        if (req.wdata[7:0] < 8'(`SSAT_SYNC_MIN_CYC))
          sync_width <= 8'(`SSAT_SYNC_MIN_CYC); // see [RULE_08]
        else if (req.wdata[7:0] > 8'(`SSAT_SYNC_MAX_CYC))
          sync_width <= 8'(`SSAT_SYNC_MAX_CYC); // see [RULE_08]
        else
          sync_width <= req.wdata[7:0];
      end
      if (hit(req.addr, `SSAT_OFF_SYNC_PERIOD))
        sync_period <= req.wdata[PERIOD_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Sync generator; double update halves the interval
  // --------------------------------------------------------------------------
  assign interval = double_update ? (sync_period >> 1) : sync_period; // see [RULE_12]
  assign start = run && (period_cnt == '0);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      period_cnt <= '0;
    else if (!run)
      period_cnt <= '0;
    else if (period_cnt + PERIOD_W'(1) >= interval)
      period_cnt <= '0;
    else
      period_cnt <= period_cnt + PERIOD_W'(1);
  end

  // --------------------------------------------------------------------------
  // Conversion state machine
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ssat_pkg::SSAT_ST_IDLE:
        if (start)
          next_state = ssat_pkg::SSAT_ST_SYNC;
      ssat_pkg::SSAT_ST_SYNC:
        if (width_cnt <= 8'h01)
          next_state = ssat_pkg::SSAT_ST_RAMP;
      ssat_pkg::SSAT_ST_RAMP:
        if (start)
          next_state = ssat_pkg::SSAT_ST_SYNC; // see [RULE_07]
        else if (!run)
          next_state = ssat_pkg::SSAT_ST_IDLE;
      default:
        next_state = ssat_pkg::SSAT_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= ssat_pkg::SSAT_ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      width_cnt <= '0;
    else if (start)
      width_cnt <= sync_width; // see [RULE_08]
    else if (width_cnt != '0)
      width_cnt <= width_cnt - 8'h01;
  end

  // --------------------------------------------------------------------------
  // Shared ramp counter, core rate or half rate
  // --------------------------------------------------------------------------
  assign tick = mode.rate | half_tick; // see [RULE_10]

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      half_tick <= 1'b0;
    else if (state != ssat_pkg::SSAT_ST_RAMP)
      half_tick <= 1'b0;
    else
      half_tick <= ~half_tick;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (state != ssat_pkg::SSAT_ST_RAMP)
      count <= '0; // see [RULE_18]
    else if (tick && count != CNT_W'(`SSAT_FULL_SCALE))
      count <= count + CNT_W'(1); // see [RULE_05] [RULE_11]
  end

  // --------------------------------------------------------------------------
  // Four captures on the one counter; channel four is the selected aux
  // --------------------------------------------------------------------------
  // A short sync leaves old trips in the synchronisers; wait them out
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      settle <= 3'h0;
    else if (start)
      settle <= `SSAT_TRIP_FLUSH; // see [RULE_19]
    else if (settle != 3'h0)
      settle <= settle - 3'h1;
  end

  assign capture_ok = (state == ssat_pkg::SSAT_ST_RAMP) && (settle == 3'h0);

  for (genvar ch = 0; ch < 4; ch++)
  begin : g_cap
    ssat_capture #(
      .WIDTH(CNT_W)
    ) u_cap (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .start_i(start), // see [RULE_07]
      .ramp_i(capture_ok),
      .trip_i(trip[ch]), // see [RULE_01]
      .count_i(count),
      .result_o(result[ch])
    );
  end

  // --------------------------------------------------------------------------
  // Analog control outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aux_select_o <= 2'h0;
      ramp_current_trim_o <= `SSAT_RST_TRIM;
      ramp_discharge_o <= 1'b1;
      pwm_sync_pulse_o <= 1'b0;
    end
    else
    begin
      aux_select_o <= mode.sel; // see [RULE_02] [RULE_04]
      ramp_current_trim_o <= trim; // see [RULE_15]
      ramp_discharge_o <= (next_state != ssat_pkg::SSAT_ST_RAMP); // see [RULE_07]
      pwm_sync_pulse_o <= (next_state == ssat_pkg::SSAT_ST_SYNC);
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit(req.addr, `SSAT_OFF_MODE))
      next_rdata = {21'h0, run, double_update, 1'b0, mode.rate,
                    5'h00, mode.sel};
    else if (hit(req.addr, `SSAT_OFF_SYNC_WIDTH))
      next_rdata = {24'h0, sync_width};
    else if (hit(req.addr, `SSAT_OFF_TRIM))
      next_rdata = {29'h0, trim};
    else if (hit(req.addr, `SSAT_OFF_RESULT_ONE))
      next_rdata = {20'h0, result[0]};
    else if (hit(req.addr, `SSAT_OFF_RESULT_TWO))
      next_rdata = {20'h0, result[1]};
    else if (hit(req.addr, `SSAT_OFF_RESULT_THREE))
      next_rdata = {20'h0, result[2]};
    else if (hit(req.addr, `SSAT_OFF_RESULT_AUX))
      next_rdata = {20'h0, result[3]};
    else if (hit(req.addr, `SSAT_OFF_SYNC_PERIOD))
      next_rdata = {16'h0, sync_period};
    else if (hit(req.addr, `SSAT_OFF_STATUS))
      next_rdata = {25'h0, trip, state};
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= 32'h0000_0000;
    else if (req.rd)
      rdata_o <= next_rdata;
    else
      rdata_o <= 32'h0000_0000;
  end

endmodule : ssat_timer
`default_nettype wire

// *** verif/ssat_timer_assertions.sv ***
// Assertions on the converter timer ports
`timescale 1ns/1ps
`default_nettype none
`include "ssat_defs.svh"
module ssat_timer_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [10:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Converter
  input wire logic [3:0] comp_trip_i,
  input wire logic [1:0] aux_select_o,
  input wire logic [2:0] ramp_current_trim_o,
  input wire logic ramp_discharge_o,
  input wire logic pwm_sync_pulse_o
);
  // ----
  // Helpers
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [8:0] sync_len;
  logic wr_trim;
  logic wr_mode;
  assign wr_trim = wr_i && addr_i == `SSAT_OFF_TRIM;
  assign wr_mode = wr_i && addr_i == `SSAT_OFF_MODE;
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      sync_len <= 9'h000;
    else if (!pwm_sync_pulse_o)
      sync_len <= 9'h000;
    else if (sync_len != 9'h1ff)
      sync_len <= sync_len + 9'h001;
  // ----
  // Properties
  // ----
  property p_trim_rst;
    $rose(arst_n_i) |-> ramp_current_trim_o == 3'h0;
  endproperty
  property p_trim_wr;
    wr_trim ##1 !wr_trim |=> ramp_current_trim_o == $past(wdata_i[2:0], 2);
  endproperty
  property p_trim_rd;
    $past(rd_i) && $past(addr_i) == `SSAT_OFF_TRIM
      |-> rdata_o == {29'h0, ramp_current_trim_o};
  endproperty
  property p_sel_rst;
    $rose(arst_n_i) |-> aux_select_o == 2'h0;
  endproperty
  property p_sel_wr;
    wr_mode ##1 !wr_mode |=> aux_select_o == $past(wdata_i[1:0], 2);
  endproperty
  property p_disch;
    pwm_sync_pulse_o |-> ramp_discharge_o;
  endproperty
  property p_sync_end;
    $fell(pwm_sync_pulse_o) |-> !ramp_discharge_o;
  endproperty
  property p_sync_max;
    sync_len <= `SSAT_SYNC_MAX_CYC;
  endproperty
  a_trim_rst: assert property (p_trim_rst)
    else $error("trim not zero after reset");
  a_trim_wr: assert property (p_trim_wr)
    else $error("trim output does not follow write");
  a_trim_rd: assert property (p_trim_rd)
    else $error("trim read back differs");
  a_sel_rst: assert property (p_sel_rst)
    else $error("selector not zero after reset");
  a_sel_wr: assert property (p_sel_wr)
    else $error("selector does not follow mode");
  a_disch: assert property (p_disch)
    else $error("sync without discharge");
  a_sync_end: assert property (p_sync_end)
    else $error("ramp not released at sync end");
  a_sync_max: assert property (p_sync_max)
    else $error("sync pulse too long");
  c_sync: cover property ($rose(pwm_sync_pulse_o));
  c_trip: cover property ($rose(comp_trip_i[3]));
  c_trim: cover property (wr_trim);
endmodule : ssat_timer_chk
bind ssat_timer ssat_timer_chk i_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .comp_trip_i(comp_trip_i),
  .aux_select_o(aux_select_o), .ramp_current_trim_o(ramp_current_trim_o),
  .ramp_discharge_o(ramp_discharge_o), .pwm_sync_pulse_o(pwm_sync_pulse_o));
`default_nettype wire

// *** verif/ssat_comp_model.sv ***
// Ramp and comparator model on the converter's far side
`timescale 1ns/1ps
`default_nettype none
module ssat_comp_model (
  // Clock
  input wire logic clk_i,
  // From the timer
  input wire logic ramp_discharge_i,
  input wire logic [1:0] aux_select_i,
  input wire logic [2:0] ramp_current_trim_i,
  // Crossing times in ramp cycles: main 0..2, aux 0..2, reference
  input wire logic [6:0][15:0] thr_i,
  // Comparator outputs
  output logic [3:0] comp_trip_o
);
  logic [15:0] ramp_cyc;
  logic [15:0] ref_cyc;
  // Stronger ramp current reaches the reference sooner
  assign ref_cyc = thr_i[6] - {8'h00, ramp_current_trim_i, 5'h00};
  always @(posedge clk_i)
    if (ramp_discharge_i)
      ramp_cyc <= 16'h0000;
    else if (ramp_cyc != 16'hffff)
      ramp_cyc <= ramp_cyc + 16'h0001;
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      comp_trip_o[i] = !ramp_discharge_i && ramp_cyc >= thr_i[i];
    comp_trip_o[3] = !ramp_discharge_i && ramp_cyc >=
      (aux_select_i == 2'h3 ? ref_cyc : thr_i[3 + aux_select_i]);
  end
endmodule : ssat_comp_model
`default_nettype wire

// *** verif/ssat_timer_tb.sv ***
// Self-checking bench of the converter timer
`timescale 1ns/1ps
`default_nettype none
module ssat_timer_tb;
  typedef struct packed {
    logic rate;
    logic [1:0] sel;
    logic [2:0][15:0] m;
  } ssat_row_t;
  logic clk_i = 1'b0;
  logic arst_n_i, wr_i, rd_i, ramp_discharge_o, pwm_sync_pulse_o;
  logic [10:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [3:0] comp_trip_i;
  logic [1:0] aux_select_o;
  logic [2:0] ramp_current_trim_o;
  logic [6:0][15:0] thr;
  int bad_count = 0;
  int checks = 0;
  int n;
  logic [10:0] ra [6] = '{11'h000, 11'h004, 11'h008, 11'h01c, 11'h020,
    11'h7fc};
  logic [31:0] rv [6] = '{32'h0, 32'h28, 32'h0, 32'h2000, 32'h1, 32'h0};
  ssat_row_t rows [4] = '{
    '{1'b1, 2'h0, {16'h1388, 16'h012c, 16'h0064}},
    '{1'b0, 2'h1, {16'h00c8, 16'h0384, 16'h0050}},
    '{1'b1, 2'h2, {16'h0032, 16'h1388, 16'h0190}},
    '{1'b0, 2'h3, {16'h1388, 16'h0032, 16'h02bc}}};
  always #25 clk_i = ~clk_i;
  ssat_timer i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .comp_trip_i(comp_trip_i), .aux_select_o(aux_select_o),
    .ramp_current_trim_o(ramp_current_trim_o),
    .ramp_discharge_o(ramp_discharge_o), .pwm_sync_pulse_o(pwm_sync_pulse_o));
  ssat_comp_model i_comp (.clk_i(clk_i), .ramp_discharge_i(ramp_discharge_o),
    .aux_select_i(aux_select_o), .ramp_current_trim_i(ramp_current_trim_o),
    .thr_i(thr), .comp_trip_o(comp_trip_i));
  // ----
  // Tasks
  // ----
  task automatic summarize;
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wr_reg(input logic [10:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [10:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd_reg
  task automatic wait_rise(output int k);
    logic prev;
    k = 0;
    prev = 1'b1;
    while (!(prev === 1'b0 && pwm_sync_pulse_o === 1'b1))
    begin
      prev = pwm_sync_pulse_o;
      @(posedge clk_i);
      #1;
      k++;
      if (k > 20000)
      begin
        chk(1'b0, "sync timeout");
        summarize();
      end
    end
  endtask : wait_rise
  task automatic width(output int k);
    wait_rise(k);
    k = 0;
    while (pwm_sync_pulse_o === 1'b1 && k < 300)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
  endtask : width
  function automatic logic [11:0] exp_cnt(input logic r, input logic [15:0] t);
    if (t >= 16'h03fc)
      return 12'h000;
    return r ? t[11:0] : 12'(t >> 1);
  endfunction : exp_cnt
  task automatic res_chk(input int ch, input logic [11:0] e);
    rd_reg(11'h00c + 11'(ch * 4), d);
    chk(d >= e && d <= e + 5, "result out of window");
  endtask : res_chk
  // ----
  // Sequence
  // ----
  initial
  begin
    arst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 11'h000;
    wdata_i = 32'h0;
    thr = {16'h033e, 16'h02d0, 16'h0262, 16'h01f4, 48'h0};
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(ra[i], d);
      chk(d === rv[i], "reset value");
    end
    wr_reg(11'h008, 32'hff);
    rd_reg(11'h008, d);
    chk(d === 32'h7, "trim width");
    wr_reg(11'h008, 32'h0);
    wr_reg(11'h004, 32'h4);
    wr_reg(11'h01c, 32'h400);
    for (int r = 0; r < 4; r++)
    begin
      thr[2:0] <= rows[r].m;
      wr_reg(11'h000, {21'h0, 1'b1, 2'b00, rows[r].rate, 5'h00, rows[r].sel});
      repeat (3) wait_rise(n);
      for (int c = 0; c < 3; c++)
        res_chk(c, exp_cnt(rows[r].rate, rows[r].m[c]));
      res_chk(3, exp_cnt(rows[r].rate, thr[3 + rows[r].sel]));
    end
    repeat (2) wait_rise(n);
    chk(n == 1024, "single interval");
    width(n);
    chk(n == 4, "sync width");
    wr_reg(11'h000, 32'h600);
    repeat (3) wait_rise(n);
    chk(n == 512, "double interval");
    wr_reg(11'h004, 32'h0);
    width(n);
    chk(n == 1, "sync width clamp");
    wr_reg(11'h004, 32'h4);
    wr_reg(11'h01c, 32'h1130);
    thr[2:0] <= {16'h0fff, 16'h1388, 16'h10cc};
    wr_reg(11'h000, 32'h480);
    repeat (3) wait_rise(n);
    rd_reg(11'h00c, d);
    chk(d === 32'hfff, "full scale");
    rd_reg(11'h010, d);
    chk(d === 32'h0, "no crossing");
    rd_reg(11'h00c, d);
    chk(d === 32'hfff, "result held");
    wr_reg(11'h01c, 32'h400);
    wr_reg(11'h000, 32'h483);
    for (int k = 0; k < 5; k++)
    begin
      repeat (3) wait_rise(n);
      rd_reg(11'h018, d);
      if (d > 32'h2d0)
        wr_reg(11'h008, 32'(k + 1));
    end
    rd_reg(11'h008, d);
    chk(d === 32'h4, "calibration trim");
    res_chk(3, 12'h2be);
    wr_reg(11'h008, 32'h5);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_reg(11'h008, d);
    chk(d === 32'h0, "trim after reset");
    summarize();
  end
endmodule : ssat_timer_tb
`default_nettype wire
